// ---- shared/can_ctrl_pkg.sv ----
// register map, field layout and carriers for the can transmit-select/acceptance block
// assumes one core_clk domain; engine-side events arrive as one-cycle pulses on that clock
// Operation
// R1 - abort granted sets buffer's abort acknowledge bit
// R2 - clearing transmit-empty clears abort acknowledge
// R3 - abort acknowledge read-only, held in init
// R4 - select read returns lowest set bit
// R5 - lowest set select bit picks window buffer
// R6 - window blocked while selected buffer scheduled
// R7 - no selection means no window access
// R8 - select held in init, writable outside
// R9 - software copies empty flags into select
// R10 - mode field picks filter organisation
// R11 - closed filter accepts no message
// R12 - hit field reports accepting filter number
// R13 - hit follows foreground buffer reloads
// R14 - acceptance control writable only in init
// R15 - test register reads zero, ignores writes; the code accepts writes and reads them back while special_mode is set
// R16 - transmit-empty set clears abort request
// R17 - send or granted abort sets transmit-empty
// R18 - empty selection reads as zero
package can_ctrl_pkg;

    localparam int ADDR_W = 4;                 // register address width
    localparam int NBUF   = 3;                 // transmit buffers

    // register offsets (byte addresses on the plain port)
    localparam logic [3:0] OFS_TX_EMPTY   = 4'h0;  // transmit_empty_register
    localparam logic [3:0] OFS_ABORT_REQ  = 4'h1;  // abort_request_register
    localparam logic [3:0] OFS_ABORT_ACK  = 4'h2;  // tx_abort_acknowledge
    localparam logic [3:0] OFS_TX_SELECT  = 4'h3;  // tx_buffer_select
    localparam logic [3:0] OFS_ACC_CTRL   = 4'h4;  // acceptance_control
    localparam logic [3:0] OFS_TEST_RSVD  = 4'h5;  // factory_test_reserved
    localparam logic [3:0] OFS_IRQ_STATUS = 4'h6;  // sticky event flags, write one to clear
    localparam logic [3:0] OFS_IRQ_MASK   = 4'h7;  // interrupt mask

    // field positions
    localparam int ACC_MODE_LSB = 4;           // acceptance_mode_field at 5:4
    localparam int ACC_HIT_LSB  = 0;           // filter_hit_field at 2:0
    localparam int IRQ_EMPTY_LSB = 0;          // status 2:0 transmit-empty events
    localparam int IRQ_ABORT_LSB = 3;          // status 5:3 abort events
    localparam int IRQ_RX_BIT    = 6;          // status 6 message accepted

    // reset values
    localparam logic [2:0] RST_TX_EMPTY = 3'h7; // all buffers empty
    localparam logic [2:0] RST_ZERO3    = 3'h0;
    localparam logic [1:0] RST_MODE     = 2'h0;
    localparam logic [6:0] RST_IRQ      = 7'h00;

    // filter organisation
    typedef enum logic [1:0] {
        ACC_TWO_32   = 2'b00,
        ACC_FOUR_16  = 2'b01,
        ACC_EIGHT_8  = 2'b10,
        ACC_CLOSED   = 2'b11
    } acc_mode_e;

    // software register port
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } reg_req_s;

    // engine-side event pulses
    typedef struct packed {
        logic [NBUF-1:0] sent;          // message sent successfully
        logic [NBUF-1:0] aborted;       // abort granted
        logic            rx_shift;      // new message into foreground buffer
        logic [2:0]      rx_hit;        // filter that accepted it
    } eng_evt_s;

endpackage

// ---- hdl/can_tx_select_accept_ctrl.sv ----
// transmit-select, abort acknowledge and acceptance control register block
// assumes engine events are synchronous to core_clk; init_request/init_acknowledge come
// from the mode controller on the same clock; window access strobes come from the cpu bus
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module can_tx_select_accept_ctrl
    import can_ctrl_pkg::*;
(
    input  wire logic            core_clk,        // 250 MHz module clock
    input  wire logic            arst_n,          // async reset, active low
    input  wire reg_req_s        reg_req,         // register port request
    output logic [7:0]           reg_rdata,       // read data, cycle after read strobe
    input  wire logic            init_request,    // init mode requested
    input  wire logic            init_acknowledge,// init mode acknowledged
    input  wire logic            special_mode,    // special (test) system mode
    input  wire eng_evt_s        eng_evt,         // engine event pulses
    input  wire logic            win_access,      // cpu touches transmit_access_window
    output logic                 win_grant,       // window access allowed
    output logic [NBUF-1:0]      win_buf_onehot,  // buffer mapped into the window
    output logic [NBUF-1:0]      tx_scheduled,    // buffers due for transmission
    output logic [NBUF-1:0]      abort_pending,   // abort requests to the engine
    output logic [1:0]           acc_mode,        // filter organisation to the filter
    output logic                 rx_accept_en,    // filter may accept messages
    output logic [7:0]           test_ctrl,       // factory test bits, special mode only
    output logic                 irq              // level interrupt
);

    ////////////////////////////////////////////////////////////////////////////////
    // state
    logic [NBUF-1:0] tx_empty_reg,  tx_empty_next;   // transmit_empty_flag per buffer
    logic [NBUF-1:0] abort_req_reg, abort_req_next;  // abort_request_bit per buffer
    logic [NBUF-1:0] abort_ack_reg, abort_ack_next;  // abort_acknowledge_bit per buffer
    logic [NBUF-1:0] tx_sel_reg,    tx_sel_next;     // raw select bits as written
    acc_mode_e       mode_reg,      mode_next;       // acceptance_mode_field
    logic [2:0]      hit_reg,       hit_next;        // filter_hit_field
    logic [7:0]      test_reg,      test_next;       // factory test register
    logic [6:0]      irq_st_reg,    irq_st_next;     // sticky event flags
    logic [6:0]      irq_mask_reg,  irq_mask_next;   // event mask
    logic [7:0]      rdata_reg,     rdata_next;      // read data holder
    logic            grant_reg,     grant_next;      // window grant
    logic [NBUF-1:0] win_reg,       win_next;        // mapped buffer
    logic            irq_reg,       irq_next;        // interrupt level
    logic [NBUF-1:0] sched_reg;                      // registered copy of ~transmit-empty
    logic            accept_reg;                     // registered filter-open level

    logic            in_init;       // both init handshake bits set
    logic            out_init;      // both init handshake bits clear
    logic [NBUF-1:0] sel_low;       // lowest set select bit
    logic [NBUF-1:0] empty_set;     // hardware sets transmit-empty this cycle
    logic            wr_hit_empty;  // write to transmit-empty register
    logic            wr_hit_abort;  // write to abort request register

    assign in_init  = init_request & init_acknowledge;
    assign out_init = ~init_request & ~init_acknowledge;
    assign wr_hit_empty = reg_req.wr & (reg_req.addr == OFS_TX_EMPTY);
    assign wr_hit_abort = reg_req.wr & (reg_req.addr == OFS_ABORT_REQ);

    // lowest-set-bit isolation; x & -x keeps only the lowest one
    assign sel_low   = tx_sel_reg & (~tx_sel_reg + 3'h1); // R4 R5 R18
    assign empty_set = eng_evt.sent | eng_evt.aborted;    // R17

    ////////////////////////////////////////////////////////////////////////////////
    // transmit flags, abort request/acknowledge, per buffer
    always_comb begin
        tx_empty_next  = tx_empty_reg;
        abort_req_next = abort_req_reg;
        abort_ack_next = abort_ack_reg;
        for (int i = 0; i < NBUF; i++) begin
            // software clears empty by writing one; hardware set wins a collision
            if (out_init && wr_hit_empty && reg_req.wdata[i] && !empty_set[i]) begin
                tx_empty_next[i]  = 1'b0;
                abort_ack_next[i] = 1'b0;                 // R2
            end
            // software may only raise abort requests on scheduled buffers
            if (out_init && wr_hit_abort && reg_req.wdata[i] && !tx_empty_reg[i]) begin
                abort_req_next[i] = 1'b1;
            end
            if (empty_set[i]) begin
                tx_empty_next[i]  = 1'b1;                 // R17
                abort_req_next[i] = 1'b0;                 // R16
                // acknowledge only on a granted abort, not on a sent message
                abort_ack_next[i] = eng_evt.aborted[i] & ~eng_evt.sent[i]; // R1
            end
        end
        if (in_init) begin
            // init holds these in reset; the ack register ignores all writes
            tx_empty_next  = RST_TX_EMPTY;
            abort_req_next = RST_ZERO3;
            abort_ack_next = RST_ZERO3;                   // R3
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_empty_reg  <= RST_TX_EMPTY;
            abort_req_reg <= RST_ZERO3;
            abort_ack_reg <= RST_ZERO3;
            sched_reg     <= RST_ZERO3;
        end else begin
            tx_empty_reg  <= tx_empty_next;
            // kept as its own flop so the output needs no gate behind it
            sched_reg     <= ~tx_empty_next;
            abort_req_reg <= abort_req_next;
            abort_ack_reg <= abort_ack_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // buffer select and window gating
    always_comb begin
        tx_sel_next = tx_sel_reg;
        if (in_init) begin
            tx_sel_next = RST_ZERO3;                      // R8
        end else if (out_init && reg_req.wr && reg_req.addr == OFS_TX_SELECT) begin
            tx_sel_next = reg_req.wdata[NBUF-1:0];        // R8 R9
        end
        win_next = sel_low;                               // R5
        // no selection, or selected buffer scheduled: access refused
        grant_next = win_access && (sel_low != RST_ZERO3)          // R7
                     && ((sel_low & ~tx_empty_reg) == RST_ZERO3);  // R6
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_sel_reg <= RST_ZERO3;
            win_reg    <= RST_ZERO3;
            grant_reg  <= 1'b0;
        end else begin
            tx_sel_reg <= tx_sel_next;
            win_reg    <= win_next;
            grant_reg  <= grant_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // acceptance control and factory test register
    always_comb begin
        mode_next = mode_reg;
        hit_next  = hit_reg;
        test_next = test_reg;
        // mode writable only in init; hit bits never writable
        if (in_init && reg_req.wr && reg_req.addr == OFS_ACC_CTRL) begin
            mode_next = acc_mode_e'(reg_req.wdata[ACC_MODE_LSB +: 2]); // R14 R10
        end
        // closed filter: no acceptance, so foreground never reloads
        if (eng_evt.rx_shift && mode_reg != ACC_CLOSED) begin       // R11
            hit_next = eng_evt.rx_hit;                              // R12 R13
        end
        // test bits only reachable in special mode
        if (special_mode && reg_req.wr && reg_req.addr == OFS_TEST_RSVD) begin
            test_next = reg_req.wdata;                              // R15
        end else if (!special_mode) begin
            test_next = 8'h00;                                      // R15
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= acc_mode_e'(RST_MODE);
            hit_reg  <= RST_ZERO3;
            test_reg <= 8'h00;
            accept_reg <= 1'b1;                 // reset mode is not closed
        end else begin
            mode_reg <= mode_next;
            accept_reg <= (mode_next != ACC_CLOSED);    // R11
            hit_reg  <= hit_next;
            test_reg <= test_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status and mask
    always_comb begin
        logic [6:0] ev;
        ev = 7'h00;
        ev[IRQ_EMPTY_LSB +: NBUF] = empty_set & ~tx_empty_reg;
        ev[IRQ_ABORT_LSB +: NBUF] = eng_evt.aborted & ~eng_evt.sent;
        ev[IRQ_RX_BIT]            = eng_evt.rx_shift & (mode_reg != ACC_CLOSED);
        irq_st_next   = irq_st_reg;
        irq_mask_next = irq_mask_reg;
        if (reg_req.wr && reg_req.addr == OFS_IRQ_STATUS) begin
            irq_st_next = irq_st_reg & ~reg_req.wdata[6:0];
        end
        if (reg_req.wr && reg_req.addr == OFS_IRQ_MASK) begin
            irq_mask_next = reg_req.wdata[6:0];
        end
        irq_st_next = irq_st_next | ev;   // set wins over clear
        irq_next    = |(irq_st_next & irq_mask_next);
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_st_reg   <= RST_IRQ;
            irq_mask_reg <= RST_IRQ;
            irq_reg      <= 1'b0;
        end else begin
            irq_st_reg   <= irq_st_next;
            irq_mask_reg <= irq_mask_next;
            irq_reg      <= irq_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path: data stand in the cycle after the strobe, zero otherwise
    always_comb begin
        rdata_next = 8'h00;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                OFS_TX_EMPTY:   rdata_next = {5'h00, tx_empty_reg};
                OFS_ABORT_REQ:  rdata_next = {5'h00, abort_req_reg};
                OFS_ABORT_ACK:  rdata_next = {5'h00, abort_ack_reg};    // R3
                OFS_TX_SELECT:  rdata_next = {5'h00, sel_low};          // R4 R18
                OFS_ACC_CTRL:   rdata_next = {2'h0, mode_reg, 1'b0, hit_reg}; // R14
                OFS_TEST_RSVD:  rdata_next = special_mode ? test_reg : 8'h00; // R15
                OFS_IRQ_STATUS: rdata_next = {1'b0, irq_st_reg};
                OFS_IRQ_MASK:   rdata_next = {1'b0, irq_mask_reg};
                default:        rdata_next = 8'h00;   // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs, all from flip-flops
    assign reg_rdata      = rdata_reg;
    assign win_grant      = grant_reg;
    assign win_buf_onehot = win_reg;
    assign tx_scheduled   = sched_reg;
    assign abort_pending  = abort_req_reg;
    assign acc_mode       = mode_reg;
    assign rx_accept_en   = accept_reg;
    assign test_ctrl      = test_reg;
    assign irq            = irq_reg;

endmodule

// ---- tb/can_tx_select_accept_ctrl_checker.sv ----
// port-level assertions for the transmit-select and acceptance control block
// assumes the single core_clk domain and arst_n asynchronous active low
`timescale 1ns/1ps
module can_tx_select_accept_ctrl_checker
    import can_ctrl_pkg::*;
(
    input wire logic            core_clk,         // module clock
    input wire logic            arst_n,           // async reset, active low
    input wire reg_req_s        reg_req,          // register port request
    input wire logic [7:0]      reg_rdata,        // read data
    input wire logic            init_request,     // init requested
    input wire logic            init_acknowledge, // init acknowledged
    input wire logic            special_mode,     // test mode
    input wire eng_evt_s        eng_evt,          // engine pulses
    input wire logic            win_access,       // window touch
    input wire logic            win_grant,        // window allowed
    input wire logic [NBUF-1:0] win_buf_onehot,   // mapped buffer
    input wire logic [NBUF-1:0] tx_scheduled,     // queued buffers
    input wire logic [NBUF-1:0] abort_pending,    // abort requests
    input wire logic [1:0]      acc_mode,         // filter organisation
    input wire logic            rx_accept_en,     // filter open
    input wire logic [7:0]      test_ctrl,        // factory test bits
    input wire logic            irq               // interrupt level
);
    // one domain, so clock and disable are given once
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////////////
    rdata_idle_a: assert property (!$past(reg_req.rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    accept_gate_a: assert property (rx_accept_en == (acc_mode != 2'h3))
        else $error("closed filter still accepts");
    mode_init_a: assert property ($changed(acc_mode) |->
        $past(init_request) && $past(init_acknowledge)) else $error("mode changed outside init");
    init_hold_a: assert property ($past(init_request && init_acknowledge)
        |-> tx_scheduled == 3'h0 && abort_pending == 3'h0) else $error("init hold broken");
    abort_subset_a: assert property ((abort_pending & ~tx_scheduled) == 3'h0)
        else $error("abort request on empty buffer");
    sent_empty_a: assert property (eng_evt.sent != 3'h0 |=>
        (tx_scheduled & $past(eng_evt.sent)) == 3'h0) else $error("sent buffer not empty");
    abort_empty_a: assert property (eng_evt.aborted != 3'h0 |=>
        (tx_scheduled & $past(eng_evt.aborted)) == 3'h0) else $error("aborted buffer not empty");
    window_one_a: assert property ($onehot0(win_buf_onehot))
        else $error("more than one buffer mapped");
    grant_cause_a: assert property (win_grant |-> $past(win_access))
        else $error("grant without access");
    test_quiet_a: assert property (!special_mode && !$past(special_mode)
        |-> test_ctrl == 8'h00) else $error("test bits outside special mode");
    // main scenarios reached
    cover property (eng_evt.aborted != 3'h0);
    cover property (win_grant);
    cover property (eng_evt.rx_shift && acc_mode == 2'h3);
endmodule

// ---- tb/can_engine_model.sv ----
// behavioural protocol engine facing the block's event inputs
// assumes the bench pulses go and rx_go for one cycle off the clock edge
`timescale 1ns/1ps
module can_engine_model
    import can_ctrl_pkg::*;
(
    input  wire logic [NBUF-1:0] go,            // bench asks buffers to finish
    input  wire logic            rx_go,         // a message reaches the foreground
    input  wire logic [2:0]      rx_hit_in,     // accepting filter number
    input  wire logic [NBUF-1:0] tx_scheduled,  // buffers queued by software
    input  wire logic [NBUF-1:0] abort_pending, // abort requests from software
    output eng_evt_s             eng_evt        // event pulses to the block
);
    // a pending abort is granted instead of sending; idle buffers stay silent
    always_comb begin
        eng_evt.aborted  = go & tx_scheduled & abort_pending;
        eng_evt.sent     = go & tx_scheduled & ~abort_pending;
        eng_evt.rx_shift = rx_go;
        // hit is garbage outside the pulse so a stale value cannot pass
        eng_evt.rx_hit   = rx_go ? rx_hit_in : ~rx_hit_in;
    end
endmodule

// ---- tb/can_tx_select_accept_ctrl_bench.sv ----
// self-checking bench: register tasks, engine model, bound checker
// assumes the register map of can_ctrl_pkg and a 4 ns core_clk
`timescale 1ns/1ps
module can_tx_select_accept_ctrl_bench
    import can_ctrl_pkg::*;
;
    logic core_clk = 0, arst_n = 0, init_request, init_acknowledge, special_mode;
    logic win_access, win_grant, rx_go, rx_accept_en, irq;
    logic [2:0] go, rx_hit_in, win_buf_onehot, tx_scheduled, abort_pending;
    logic [1:0] acc_mode;
    logic [7:0] reg_rdata, test_ctrl;
    reg_req_s   reg_req;
    eng_evt_s   eng_evt;
    int         fail_count = 0, n_compared = 0, cycles = 0;
    can_tx_select_accept_ctrl can_tx_select_accept_ctrl_inst (.core_clk(core_clk),
        .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .init_request(init_request),
        .init_acknowledge(init_acknowledge), .special_mode(special_mode), .eng_evt(eng_evt),
        .win_access(win_access), .win_grant(win_grant), .win_buf_onehot(win_buf_onehot),
        .tx_scheduled(tx_scheduled), .abort_pending(abort_pending), .acc_mode(acc_mode),
        .rx_accept_en(rx_accept_en), .test_ctrl(test_ctrl), .irq(irq));
    can_engine_model can_engine_model_inst (.go(go), .rx_go(rx_go), .rx_hit_in(rx_hit_in),
        .tx_scheduled(tx_scheduled), .abort_pending(abort_pending), .eng_evt(eng_evt));
    always #2 core_clk = ~core_clk;
    // hang guard, runs far beyond the few hundred cycles used
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk) reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk) reg_req.wr <= 1'b0;
    endtask
    // data stand only in the cycle after the strobe
    task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string w);
        @(posedge core_clk) reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk) reg_req.rd <= 1'b0;
        #1 chk(w, e, reg_rdata);
    endtask
    task automatic mode(input logic b);
        @(posedge core_clk) {init_request, init_acknowledge} <= {b, b};
        @(posedge core_clk);
    endtask
    task automatic fire(input logic [2:0] b);
        @(posedge core_clk) go <= b;
        @(posedge core_clk) go <= 3'h0;
    endtask
    task automatic rx(input logic [2:0] h);
        @(posedge core_clk) {rx_go, rx_hit_in} <= {1'b1, h};
        @(posedge core_clk) rx_go <= 1'b0;
    endtask
    task automatic win(input logic e);
        @(posedge core_clk) win_access <= 1'b1;
        @(posedge core_clk) win_access <= 1'b0;
        #1 chk("grant", {7'h00, e}, {7'h00, win_grant});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int i = 0; i < 9; i++) rchk(i[3:0], i == 0 ? 8'h07 : 8'h00, "reset value");
        $display("test reset done");
    endtask
    task automatic t_select;
        logic [7:0] e;
        for (int v = 0; v < 8; v++) begin
            e = v[7:0] & (~v[7:0] + 8'h01);
            wr(4'h3, v[7:0]);
            rchk(4'h3, e, "select read");
            chk("mapped buffer", e, {5'h00, win_buf_onehot});
        end
        wr(4'h3, 8'h07); // software copies the empty flags
        rchk(4'h3, 8'h01, "select from empty");
        $display("test select done");
    endtask
    task automatic t_window;
        wr(4'h3, 8'h01); win(1'b1);
        wr(4'h0, 8'h01); win(1'b0);
        wr(4'h3, 8'h03); win(1'b0);
        wr(4'h3, 8'h02); win(1'b1);
        wr(4'h3, 8'h00); win(1'b0);
        fire(3'b001);
        $display("test window done");
    endtask
    task automatic t_abort;
        wr(4'h0, 8'h01); wr(4'h1, 8'h01); fire(3'b001);
        rchk(4'h2, 8'h01, "abort ack");
        rchk(4'h0, 8'h07, "empty after abort");
        rchk(4'h1, 8'h00, "abort request");
        wr(4'h2, 8'h00); rchk(4'h2, 8'h01, "ack write");
        wr(4'h0, 8'h01); rchk(4'h2, 8'h00, "ack clear");
        fire(3'b001); rchk(4'h2, 8'h00, "ack after send");
        rchk(4'h0, 8'h07, "empty after send");
        $display("test abort done");
    endtask
    task automatic t_irq;
        wr(4'h6, 8'hFF); wr(4'h7, 8'h00); wr(4'h0, 8'h02); fire(3'b010);
        rchk(4'h6, 8'h02, "status event");
        chk("irq masked", 8'h00, {7'h00, irq});
        wr(4'h7, 8'h02); rchk(4'h7, 8'h02, "mask");
        chk("irq raised", 8'h01, {7'h00, irq});
        wr(4'h6, 8'h02); rchk(4'h6, 8'h00, "status clear");
        chk("irq cleared", 8'h00, {7'h00, irq});
        $display("test irq done");
    endtask
    task automatic t_accept;
        mode(1'b1);
        for (int m = 0; m < 4; m++) begin
            wr(4'h4, {2'h0, m[1:0], 4'h7});
            rchk(4'h4, {2'h0, m[1:0], 4'h0}, "mode write");
        end
        mode(1'b0); rx(3'h2); rchk(4'h4, 8'h30, "closed filter");
        mode(1'b1); wr(4'h4, 8'h10); mode(1'b0);
        rx(3'h5); rchk(4'h4, 8'h15, "filter hit");
        wr(4'h4, 8'h20); rchk(4'h4, 8'h15, "write outside init");
        $display("test accept done");
    endtask
    task automatic t_init;
        wr(4'h3, 8'h04); mode(1'b1);
        rchk(4'h3, 8'h00, "select in init");
        rchk(4'h2, 8'h00, "ack in init");
        wr(4'h3, 8'h01); mode(1'b0);
        rchk(4'h3, 8'h00, "select write in init");
        wr(4'h5, 8'hA5); rchk(4'h5, 8'h00, "test register");
        chk("test bits", 8'h00, test_ctrl);
        @(posedge core_clk) special_mode <= 1'b1;
        wr(4'h5, 8'hA5); rchk(4'h5, 8'hA5, "test write special");
        chk("test bits special", 8'hA5, test_ctrl);
        @(posedge core_clk) special_mode <= 1'b0;
        @(posedge core_clk);
        #1 chk("test bits cleared", 8'h00, test_ctrl);
        wr(4'h8, 8'hFF); rchk(4'h8, 8'h00, "unmapped");
        $display("test init done");
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        reg_req = '0; {init_request, init_acknowledge, special_mode} = 3'h0;
        {win_access, rx_go, go, rx_hit_in} = 8'h00;
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        t_reset(); t_select(); t_window(); t_abort(); t_irq(); t_accept(); t_init();
        stop_test();
    end
endmodule
bind can_tx_select_accept_ctrl can_tx_select_accept_ctrl_checker checker_inst (
    .core_clk(core_clk), .arst_n(arst_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .init_request(init_request), .init_acknowledge(init_acknowledge),
    .special_mode(special_mode), .eng_evt(eng_evt), .win_access(win_access),
    .win_grant(win_grant), .win_buf_onehot(win_buf_onehot), .tx_scheduled(tx_scheduled),
    .abort_pending(abort_pending), .acc_mode(acc_mode), .rx_accept_en(rx_accept_en),
    .test_ctrl(test_ctrl), .irq(irq));
